// ---- inc/ipic_consts.svh ----
// offsets, field positions, reset values and timing figures of the input pin / irq block
`ifndef IPIC_CONSTS_SVH
`define IPIC_CONSTS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define IPIC_ADDR_FUNC_SEL   8'h2B
`define IPIC_ADDR_LEVEL_MON  8'h2F
`define IPIC_ADDR_IRQ_SETUP  8'h32
`define IPIC_ADDR_IRQ_MASK   8'h33
`define IPIC_ADDR_IRQ_LATCH  8'h36
// ----------------------------------------------------------------
// field positions and writable bits
// ----------------------------------------------------------------
`define IPIC_FIRST_SEL_HI    6
`define IPIC_FIRST_SEL_LO    4
`define IPIC_SECOND_SEL_HI   2
`define IPIC_SECOND_SEL_LO   0
`define IPIC_FIRST_MON_BIT   7
`define IPIC_SECOND_MON_BIT  6
`define IPIC_POL_BIT         7
`define IPIC_STYLE_HI        6
`define IPIC_STYLE_LO        5
`define IPIC_FILTER_BIT      2
`define IPIC_SRC_HI          7
`define IPIC_SRC_LO          3
`define IPIC_FUNC_SEL_WMASK  8'h77
`define IPIC_IRQ_SETUP_WMASK 8'hE4
// ----------------------------------------------------------------
// reset values and the irq pin selector code
// ----------------------------------------------------------------
`define IPIC_FUNC_SEL_RST    8'h00
`define IPIC_IRQ_SETUP_RST   8'h00
`define IPIC_IRQ_MASK_RST    8'hFF
`define IPIC_IRQ_LATCH_RST   5'h00
`define IPIC_PIN_SEL_IRQ     4'h2
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define IPIC_CLK_HZ          25000000
`define IPIC_PULSE_MS        2
`define IPIC_PERIOD_MS       4
`endif

// ---- inc/ipic_pkg.sv ----
// types shared by the input pin / irq block
package ipic_pkg;
  // pin function encoding, in selector order
  typedef enum logic [2:0] {
    FN_OFF, FN_GPI, FN_MASTER_CLK, FN_SERIAL_DATA, FN_PDM_A, FN_PDM_B, FN_RSVD, FN_ADC_PD
  } ipic_func_t;
  // irq event style
  typedef enum logic [1:0] {EV_LEVEL, EV_BAD, EV_REPEAT, EV_ONCE} ipic_style_t;
  // pulse timer state
  typedef enum logic {T_IDLE, T_RUN} ipic_tstate_t;
  // signals routed from the input pins to the converter core
  typedef struct packed {
    logic master_clk;
    logic serial_data;
    logic pdm_a;
    logic pdm_b;
    logic adc_power_down;
  } ipic_route_t;
endpackage

// ---- rtl/ipic_pulse_timer.sv ----
// pulse shaper for the repeating and one-shot irq styles
`timescale 1ns/1ns
module ipic_pulse_timer #(
  parameter int unsigned PULSE_CYCLES  = 50000,
  parameter int unsigned PERIOD_CYCLES = 100000
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic repeat_en,
  input  wire logic once_en,
  input  wire logic pending,
  input  wire logic evt,
  output logic      active
);
  ipic_pkg::ipic_tstate_t st_q, st_d;
  logic [31:0]            cnt_q, cnt_d;

  // ----------------------------------------------------------------
  // next state: cycles of the block clock stand for the time base
  // ----------------------------------------------------------------
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      ipic_pkg::T_IDLE: begin
        cnt_d = 32'h0;
        if ((repeat_en && pending) || (once_en && evt)) begin
          st_d = ipic_pkg::T_RUN;
        end
      end
      ipic_pkg::T_RUN: begin
        if (repeat_en) begin
          if (!pending) begin
            st_d  = ipic_pkg::T_IDLE;
            cnt_d = 32'h0;
          end else begin
            // wrap keeps the high/low duty running while pending
            cnt_d = (cnt_q == PERIOD_CYCLES - 1) ? 32'h0 : cnt_q + 32'h1;
          end
        end else if (once_en) begin
          // events during the pulse do not stretch it
          if (cnt_q == PULSE_CYCLES - 1) begin
            st_d  = ipic_pkg::T_IDLE;
            cnt_d = 32'h0;
          end else begin
            cnt_d = cnt_q + 32'h1;
          end
        end else begin
          st_d  = ipic_pkg::T_IDLE;
          cnt_d = 32'h0;
        end
      end
      default: begin
        st_d  = ipic_pkg::T_IDLE;
        cnt_d = 32'h0;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q  <= ipic_pkg::T_IDLE;
      cnt_q <= 32'h0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // high for the first pulse-length part of each run and of each wrapped repeating period
  assign active = (st_q == ipic_pkg::T_RUN) && (cnt_q < PULSE_CYCLES);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_once_holds_high: assert property (@(posedge clk) disable iff (rst)
    (once_en && $rose(active)) |-> active [*8])
    else $error("one-shot irq pulse ended early");
  a_repeat_wraps: assert property (@(posedge clk) disable iff (rst)
    (repeat_en && pending && st_q == ipic_pkg::T_RUN && cnt_q == PERIOD_CYCLES - 1)
    |=> (cnt_q == 32'h0) && active)
    else $error("repeating irq period did not restart");
  c_once_pulse: cover property (@(posedge clk) disable iff (rst) once_en && $fell(active));
  c_repeat_wrap: cover property (@(posedge clk) disable iff (rst)
    repeat_en && st_q == ipic_pkg::T_RUN && cnt_q == PERIOD_CYCLES - 1);
endmodule // ipic_pulse_timer

// ---- rtl/ipic_top.sv ----
// input pin function routing, level monitor and irq output shaping
`timescale 1ns/1ns
`include "ipic_consts.svh"
module ipic_top #(
  parameter int unsigned PULSE_CYCLES  = `IPIC_PULSE_MS * (`IPIC_CLK_HZ / 1000),
  parameter int unsigned PERIOD_CYCLES = `IPIC_PERIOD_MS * (`IPIC_CLK_HZ / 1000)
) (
  input  wire logic       CLOCK,
  input  wire logic       RST,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  input  wire logic       FIRST_INPUT_PIN,
  input  wire logic       MIC_BIAS_PIN,
  input  wire logic [4:0] IRQ_EVENTS,
  input  wire logic [3:0] BIDIR_PIN_FUNCTION_SEL,
  output logic            MASTER_CLK_IN,
  output logic            SERIAL_AUDIO_DATA_IN,
  output logic            PDM_DATA_PAIR_A,
  output logic            PDM_DATA_PAIR_B,
  output logic            ADC_POWER_DOWN,
  output logic            IRQ_PIN_OUT,
  output logic            IRQ_PIN_OE
);
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0]                func_sel_q, func_sel_d;
  logic [7:0]                irq_setup_q, irq_setup_d;
  logic [7:0]                irq_mask_q, irq_mask_d;
  logic [4:0]                latch_q, latch_d;
  logic [7:0]                rdata_d;
  logic [7:0]                level_mon;
  logic [4:0]                latch_view;
  ipic_pkg::ipic_func_t      first_sel, second_sel;
  ipic_pkg::ipic_style_t     style;
  ipic_pkg::ipic_route_t     route_q, route_d;
  logic                      pol, filter, pending, evt, timer_active, irq_active, irq_pin_d;
  logic                      irq_pin_q;
  logic                      rd_latch;

  // pick a pin's signal for a function, first pin taking priority
  function automatic logic pick(input ipic_pkg::ipic_func_t s1, input ipic_pkg::ipic_func_t s2,
                                input ipic_pkg::ipic_func_t fn, input logic p1,
                                input logic p2);
    pick = (s1 == fn) ? p1 : ((s2 == fn) ? p2 : 1'b0);
  endfunction

  // field decode
  assign first_sel  = ipic_pkg::ipic_func_t'(func_sel_q[`IPIC_FIRST_SEL_HI:`IPIC_FIRST_SEL_LO]);
  assign second_sel = ipic_pkg::ipic_func_t'(func_sel_q[`IPIC_SECOND_SEL_HI:`IPIC_SECOND_SEL_LO]);
  assign style      = ipic_pkg::ipic_style_t'(irq_setup_q[`IPIC_STYLE_HI:`IPIC_STYLE_LO]);
  assign pol        = irq_setup_q[`IPIC_POL_BIT];
  assign filter     = irq_setup_q[`IPIC_FILTER_BIT];
  assign rd_latch   = REG_RD && (REG_ADDR == `IPIC_ADDR_IRQ_LATCH);

  // ----------------------------------------------------------------
  // monitor and latch views
  // ----------------------------------------------------------------
  always_comb begin
    level_mon = 8'h00;
    level_mon[`IPIC_FIRST_MON_BIT]  = (first_sel == ipic_pkg::FN_GPI) && FIRST_INPUT_PIN;
    level_mon[`IPIC_SECOND_MON_BIT] = (second_sel == ipic_pkg::FN_GPI) && MIC_BIAS_PIN;
    // filter on hides masked sources from software
    latch_view = filter ? (latch_q & ~irq_mask_q[`IPIC_SRC_HI:`IPIC_SRC_LO]) : latch_q;
  end

  // ----------------------------------------------------------------
  // register writes, latch set/clear, read data
  // ----------------------------------------------------------------
  always_comb begin
    func_sel_d  = func_sel_q;
    irq_setup_d = irq_setup_q;
    irq_mask_d  = irq_mask_q;
    rdata_d     = 8'h00;
    if (REG_WR) begin
      case (REG_ADDR)
        `IPIC_ADDR_FUNC_SEL:  func_sel_d  = REG_WDATA & `IPIC_FUNC_SEL_WMASK;
        `IPIC_ADDR_IRQ_SETUP: irq_setup_d = REG_WDATA & `IPIC_IRQ_SETUP_WMASK;
        `IPIC_ADDR_IRQ_MASK:  irq_mask_d  = REG_WDATA;
        default:              func_sel_d  = func_sel_q;
      endcase
    end
    // only the bits shown are cleared; a new event in the same cycle stays set
    latch_d = (rd_latch ? (latch_q & ~latch_view) : latch_q) | IRQ_EVENTS;
    if (REG_RD) begin
      case (REG_ADDR)
        `IPIC_ADDR_FUNC_SEL:  rdata_d = func_sel_q;
        `IPIC_ADDR_LEVEL_MON: rdata_d = level_mon;
        `IPIC_ADDR_IRQ_SETUP: rdata_d = irq_setup_q;
        `IPIC_ADDR_IRQ_MASK:  rdata_d = irq_mask_q;
        `IPIC_ADDR_IRQ_LATCH: rdata_d = {latch_view, 3'h0};
        default:              rdata_d = 8'h00;
      endcase
    end
  end

  // register file flops; read data holds until the next read
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      func_sel_q  <= `IPIC_FUNC_SEL_RST;
      irq_setup_q <= `IPIC_IRQ_SETUP_RST;
      irq_mask_q  <= `IPIC_IRQ_MASK_RST;
      latch_q     <= `IPIC_IRQ_LATCH_RST;
      REG_RDATA   <= 8'h00;
    end else begin
      func_sel_q  <= func_sel_d;
      irq_setup_q <= irq_setup_d;
      irq_mask_q  <= irq_mask_d;
      latch_q     <= latch_d;
      if (REG_RD) begin
        REG_RDATA <= rdata_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin function routing
  // ----------------------------------------------------------------
  always_comb begin
    route_d.master_clk  = pick(first_sel, second_sel, ipic_pkg::FN_MASTER_CLK,
                               FIRST_INPUT_PIN, MIC_BIAS_PIN);
    route_d.serial_data = pick(first_sel, second_sel, ipic_pkg::FN_SERIAL_DATA,
                               FIRST_INPUT_PIN, MIC_BIAS_PIN);
    route_d.pdm_a       = pick(first_sel, second_sel, ipic_pkg::FN_PDM_A,
                               FIRST_INPUT_PIN, MIC_BIAS_PIN);
    route_d.pdm_b       = pick(first_sel, second_sel, ipic_pkg::FN_PDM_B,
                               FIRST_INPUT_PIN, MIC_BIAS_PIN);
    // either pin may hold off all converter channels
    route_d.adc_power_down = ((first_sel == ipic_pkg::FN_ADC_PD) && FIRST_INPUT_PIN) ||
                             ((second_sel == ipic_pkg::FN_ADC_PD) && MIC_BIAS_PIN);
  end

  // ----------------------------------------------------------------
  // irq shaping
  // ----------------------------------------------------------------
  assign pending = |(latch_q & ~irq_mask_q[`IPIC_SRC_HI:`IPIC_SRC_LO]);
  assign evt     = |(IRQ_EVENTS & ~irq_mask_q[`IPIC_SRC_HI:`IPIC_SRC_LO]);

  ipic_pulse_timer #(
    .PULSE_CYCLES  (PULSE_CYCLES),
    .PERIOD_CYCLES (PERIOD_CYCLES)
  ) u_timer (
    .clk       (CLOCK),
    .rst       (RST),
    .repeat_en (style == ipic_pkg::EV_REPEAT),
    .once_en   (style == ipic_pkg::EV_ONCE),
    .pending   (pending),
    .evt       (evt),
    .active    (timer_active)
  );

  // the unused style is treated like the level style
  always_comb begin
    irq_active = ((style == ipic_pkg::EV_LEVEL) || (style == ipic_pkg::EV_BAD)) ? pending
                                                                               : timer_active;
    irq_pin_d  = pol ? irq_active : !irq_active;
  end

  // output flops; pin starts deasserted for active low
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      route_q   <= '0;
      irq_pin_q <= 1'b1;
    end else begin
      route_q   <= route_d;
      irq_pin_q <= irq_pin_d;
    end
  end

  assign MASTER_CLK_IN        = route_q.master_clk;
  assign SERIAL_AUDIO_DATA_IN = route_q.serial_data;
  assign PDM_DATA_PAIR_A      = route_q.pdm_a;
  assign PDM_DATA_PAIR_B      = route_q.pdm_b;
  assign ADC_POWER_DOWN       = route_q.adc_power_down;
  assign IRQ_PIN_OUT          = irq_pin_q;
  assign IRQ_PIN_OE           = (BIDIR_PIN_FUNCTION_SEL == `IPIC_PIN_SEL_IRQ);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_first_mon_level: assert property (@(posedge CLOCK) disable iff (RST)
    (REG_RD && REG_ADDR == `IPIC_ADDR_LEVEL_MON && first_sel == ipic_pkg::FN_GPI)
    |=> REG_RDATA[7] == $past(FIRST_INPUT_PIN))
    else $error("first input level not on monitor bit 7");
  a_first_mon_off: assert property (@(posedge CLOCK) disable iff (RST)
    (REG_RD && REG_ADDR == `IPIC_ADDR_LEVEL_MON && first_sel != ipic_pkg::FN_GPI)
    |=> !REG_RDATA[7])
    else $error("monitor bit 7 set while not gpi");
  a_second_mon_level: assert property (@(posedge CLOCK) disable iff (RST)
    (REG_RD && REG_ADDR == `IPIC_ADDR_LEVEL_MON && second_sel == ipic_pkg::FN_GPI)
    |=> REG_RDATA[6] == $past(MIC_BIAS_PIN) && REG_RDATA[5:0] == 6'h00)
    else $error("mic bias level not on monitor bit 6");
  a_sel_reserved_zero: assert property (@(posedge CLOCK) disable iff (RST)
    (REG_RD && REG_ADDR == `IPIC_ADDR_FUNC_SEL) |=> !REG_RDATA[7] && !REG_RDATA[3])
    else $error("reserved selector bits read nonzero");
  a_level_irq_follow: assert property (@(posedge CLOCK) disable iff (RST)
    (style == ipic_pkg::EV_LEVEL && pending) |=> IRQ_PIN_OUT == $past(pol))
    else $error("level irq not asserted while pending");
  a_irq_idle_polarity: assert property (@(posedge CLOCK) disable iff (RST)
    (style == ipic_pkg::EV_LEVEL && !pending) |=> IRQ_PIN_OUT == !$past(pol))
    else $error("idle irq level wrong for polarity");
  a_latch_set_wins: assert property (@(posedge CLOCK) disable iff (RST)
    (IRQ_EVENTS != 5'h00) |=> (latch_q & $past(IRQ_EVENTS)) == $past(IRQ_EVENTS))
    else $error("event lost from latch");
  a_latch_read_clears: assert property (@(posedge CLOCK) disable iff (RST)
    (rd_latch && !filter && IRQ_EVENTS == 5'h00) |=> latch_q == 5'h00)
    else $error("latch not cleared by read");
  a_filter_hides_masked: assert property (@(posedge CLOCK) disable iff (RST)
    (rd_latch && filter) |=> (REG_RDATA[7:3] & $past(irq_mask_q[7:3])) == 5'h00)
    else $error("masked source visible with filter on");
  c_gpi_read: cover property (@(posedge CLOCK) disable iff (RST)
    REG_RD && REG_ADDR == `IPIC_ADDR_LEVEL_MON && first_sel == ipic_pkg::FN_GPI);
  c_irq_level: cover property (@(posedge CLOCK) disable iff (RST) pending && IRQ_PIN_OE);
  c_set_and_clear: cover property (@(posedge CLOCK) disable iff (RST)
    rd_latch && IRQ_EVENTS != 5'h00);
endmodule // ipic_top

// ---- sim/ipic_host_model.sv ----
// host model that owns the register bus of the input pin / irq block
`timescale 1ns/1ns
module ipic_host_model (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  // idle bus: strobes low before the first edge
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end
  // one write; after release address and data flip so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  // one read; data is registered at the taking edge, so it is fetched just after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask
endmodule // ipic_host_model

// ---- sim/testbench.sv ----
// self-checking bench of the input pin / irq block
`timescale 1ns/1ns
module testbench;
  localparam int unsigned PULSE  = 10;
  localparam int unsigned PERIOD = 20;
  logic       clock;
  logic       rst;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       first_pin;
  logic       mic_pin;
  logic [4:0] irq_events;
  logic [3:0] bidir_sel;
  wire  [4:0] routed;
  logic       irq_pin;
  logic       irq_oe;
  logic [7:0] rd_v;
  logic [2:0] f1;
  logic [2:0] f2;
  logic [4:0] ev;
  int         fails;
  int         n_compared;
  int         seed;
  int         cnt;
  ipic_top #(.PULSE_CYCLES(PULSE), .PERIOD_CYCLES(PERIOD)) u_ipic_top (
    .CLOCK(clock), .RST(rst), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .FIRST_INPUT_PIN(first_pin), .MIC_BIAS_PIN(mic_pin), .IRQ_EVENTS(irq_events),
    .BIDIR_PIN_FUNCTION_SEL(bidir_sel), .MASTER_CLK_IN(routed[4]),
    .SERIAL_AUDIO_DATA_IN(routed[3]), .PDM_DATA_PAIR_A(routed[2]),
    .PDM_DATA_PAIR_B(routed[1]), .ADC_POWER_DOWN(routed[0]),
    .IRQ_PIN_OUT(irq_pin), .IRQ_PIN_OE(irq_oe));
  ipic_host_model u_ipic_host_model (
    .clk(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    u_ipic_host_model.rd(a, rd_v);
    chk(rd_v, exp);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // one-cycle event pulse on the source lines
  task automatic fire(input logic [4:0] e);
    step(1);
    irq_events = e;
    step(1);
    irq_events = 5'h00;
  endtask
  // counts asserted-high cycles; the repeating window is whole periods so phase does not matter
  task automatic cnt_hi(input int n);
    cnt = 0;
    repeat (n) begin
      step(1);
      cnt += (irq_pin === 1'b1);
    end
  endtask
  // expected routed outputs {mclk, sdata, pdm a, pdm b, power-down}; first pin wins, power-down is set by either pin
  function automatic logic [4:0] route_exp(input logic [2:0] a, input logic [2:0] b,
                                           input logic p1, input logic p2);
    logic [4:0] r;
    r = 5'h00;
    for (int k = 0; k < 4; k++) begin
      if (a == k + 2) r[4-k] = p1;
      else if (b == k + 2) r[4-k] = p2;
    end
    r[0] = ((a == 3'h7) & p1) | ((b == 3'h7) & p2);
    return r;
  endfunction
  task automatic close_out;
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // generous bound: the sequence needs well under 3000 cycles
  initial begin
    #(40 * 20000);
    fails++;
    close_out;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 74; fails = 0; n_compared = 0; rst = 1'b1; first_pin = 1'b0;
    mic_pin = 1'b0; irq_events = 5'h00; bidir_sel = 4'h2;
    repeat (12) @(posedge clock);
    #1;
    rst = 1'b0;
    // reset values, read-only and reserved places, unmapped offset
    rdchk(8'h2B, 8'h00);
    rdchk(8'h2F, 8'h00);
    rdchk(8'h32, 8'h00);
    rdchk(8'h33, 8'hFF);
    rdchk(8'h36, 8'h00);
    rdchk(8'h40, 8'h00);
    u_ipic_host_model.wr(8'h2B, 8'hFF);
    rdchk(8'h2B, 8'h77);
    u_ipic_host_model.wr(8'h32, 8'hFF);
    rdchk(8'h32, 8'hE4);
    u_ipic_host_model.wr(8'h2F, 8'hFF);
    rdchk(8'h2F, 8'h00);
    u_ipic_host_model.wr(8'h36, 8'hFF);
    rdchk(8'h36, 8'h00);
    u_ipic_host_model.wr(8'h32, 8'h00);
    // pin functions: every code on both pins, then random mixes with collisions
    for (int i = 0; i < 40; i++) begin
      f1 = (i < 8) ? i[2:0] : 3'($random(seed));
      f2 = (i < 8) ? 3'h7 - i[2:0] : 3'($random(seed));
      u_ipic_host_model.wr(8'h2B, {1'b0, f1, 1'b0, f2});
      first_pin = 1'($random(seed));
      mic_pin = 1'($random(seed));
      step(2);
      chk({3'h0, routed}, {3'h0, route_exp(f1, f2, first_pin, mic_pin)});
      // a pin not used as gpi must read as zero on its monitor bit
      u_ipic_host_model.rd(8'h2F, rd_v);
      chk(rd_v, {first_pin & (f1 == 3'h1), mic_pin & (f2 == 3'h1), 6'h00});
    end
    // level style, active low: held while pending, released by read-clear
    chk({7'h0, irq_pin}, 8'h01);
    u_ipic_host_model.wr(8'h33, 8'h00);
    fire(5'h10);
    step(3);
    chk({7'h0, irq_pin}, 8'h00);
    rdchk(8'h36, 8'h80);
    step(3);
    chk({7'h0, irq_pin}, 8'h01);
    rdchk(8'h36, 8'h00);
    // masked source: no irq, hidden from readback only while the filter is on
    u_ipic_host_model.wr(8'h33, 8'hFF);
    u_ipic_host_model.wr(8'h32, 8'h04);
    fire(5'h01);
    step(3);
    chk({7'h0, irq_pin}, 8'h01);
    rdchk(8'h36, 8'h00);
    u_ipic_host_model.wr(8'h32, 8'h00);
    rdchk(8'h36, 8'h08);
    // active high with random sources
    u_ipic_host_model.wr(8'h32, 8'h80);
    step(2);
    chk({7'h0, irq_pin}, 8'h00);
    u_ipic_host_model.wr(8'h33, 8'h00);
    ev = 5'($random(seed));
    ev = ev | 5'h01;
    fire(ev);
    step(3);
    chk({7'h0, irq_pin}, 8'h01);
    rdchk(8'h36, {ev, 3'h0});
    // repeating style: half of every period while pending, stops once cleared
    u_ipic_host_model.wr(8'h32, 8'hC0);
    fire(5'h02);
    step(5);
    cnt_hi(2 * PERIOD);
    chk(cnt[7:0], 8'(2 * PULSE));
    rdchk(8'h36, 8'h10);
    step(PERIOD);
    chk({7'h0, irq_pin}, 8'h00);
    // one-shot style: a single pulse per event
    u_ipic_host_model.wr(8'h32, 8'hE0);
    step(3);
    fire(5'h04);
    cnt_hi(3 * PULSE);
    chk(cnt[7:0], 8'(PULSE));
    rdchk(8'h36, 8'h20);
    // second reset mid-run: registers and irq pin return to their reset state
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    chk({7'h0, irq_pin}, 8'h01);
    rdchk(8'h32, 8'h00);
    rdchk(8'h33, 8'hFF);
    rdchk(8'h2B, 8'h00);
    // output enable follows the bidir selector
    for (int s = 0; s < 16; s++) begin
      bidir_sel = s[3:0];
      #1;
      chk({7'h0, irq_oe}, {7'h0, s == 2});
    end
    close_out;
  end
endmodule // testbench
